/* File: core/aqc_quad_ctrl.sv */
/*
   Configuration block for one analog quad: three channel control words
   reached over AHB-Lite, checked, decoded and driven to the front end.
   Assumes one AHB-Lite master, single word transfers, one clock.
*/
// ====================================================================
// ====================================================================
module aqc_quad_ctrl
   import aqc_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite address phase
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   // AHB-Lite data phase
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Front end controls, slot 0 voltage, 1 current, 2 temperature
   output aqc_front_t [AQC_NSLOT-1:0] chan_front
);

   // ==================================================================
   // Declarations
   // ==================================================================
   aqc_state_t st_ff; // Registered state
   aqc_state_t nxt_st; // Next state
   aqc_front_t [AQC_NSLOT-1:0] dec_front; // Decoder outputs
   aqc_chan_ctrl_t wr_in; // Write data seen as a control word
   aqc_chan_ctrl_t wr_word; // Write word after checks
   aqc_err_t err_set; // Refusals found this cycle
   aqc_err_t err_clr; // Clear request from software
   logic take; // Address phase accepted
   logic [1:0] wr_slot; // Slot of pending write
   logic [1:0] rd_slot; // Slot of new read

   // Write data viewed as channel control lines
   assign wr_in = aqc_chan_ctrl_t'(hwdata[AQC_CTRL_W-1:0]);

   // Pending write and read slots from the address
   assign wr_slot = aqc_slot_of(st_ff.waddr);
   assign rd_slot = aqc_slot_of(haddr);

   // Transfer accepted when selected, active, word wide and ready
   assign take = hsel && htrans[AQC_HTRANS_ACT] && hready && (hsize == AQC_HSIZE_WORD);

   // ==================================================================
   // Channel decoders
   // ==================================================================
   generate
      for (genvar g = 0; g < AQC_NSLOT; g++)
      begin : g_dec
         // One decoder per stored control word
         aqc_chan_decode u_dec (
            .ctrl (st_ff.ctrl[g]),
            .front (dec_front[g])
         );
      end
   endgenerate

   // ==================================================================
   // Write checking
   // ==================================================================
   // Refuses settings the analog side cannot take and flags them
   always_comb
   begin
      wr_word = wr_in;
      err_set = '0;
      // Unused source code keeps the previous source
      if (wr_in.src == AQC_SRC_INVALID && wr_slot != AQC_SLOT_NONE)
      begin
         wr_word.src = st_ff.ctrl[wr_slot].src;
         err_set.src_bad[wr_slot] = 1'b1;
      end
      // Temperature channel takes positive input only
      if (wr_slot == AQC_SLOT_TEMP && wr_in.neg_pol)
      begin
         wr_word.neg_pol = 1'b0;
         err_set.tpol_bad = 1'b1;
      end
      // Temperature channel keeps its range unless the code is allowed
      if (wr_slot == AQC_SLOT_TEMP && !aqc_temp_rng_ok(wr_in.rng))
      begin
         wr_word.rng = st_ff.ctrl[AQC_SLOT_TEMP].rng;
         err_set.trng_bad = 1'b1;
      end
      // Refusals only count during a real write data phase
      if (st_ff.bus != AQC_ST_WDATA)
      begin
         err_set = '0;
      end
   end

   // Write one to clear on the status word
   assign err_clr = (st_ff.bus == AQC_ST_WDATA && st_ff.waddr == AQC_OFF_STAT) ?
      aqc_err_t'(hwdata[AQC_ERR_W-1:0]) : '0;

   // ==================================================================
   // Next state
   // ==================================================================
   // Bus phases, register updates and front end refresh
   always_comb
   begin
      nxt_st = st_ff;
      // Bus always answers at once with OKAY
      nxt_st.ready = 1'b1;
      nxt_st.resp = AQC_HRESP_OKAY;
      // Data phase of a write stores the checked word
      case (st_ff.bus)
         AQC_ST_WDATA:
         begin
            if (wr_slot != AQC_SLOT_NONE)
            begin
               nxt_st.ctrl[wr_slot] = wr_word;
            end
         end
         AQC_ST_IDLE:
         begin
            nxt_st.bus = AQC_ST_IDLE;
         end
         default:
         begin
            nxt_st.bus = AQC_ST_IDLE;
         end
      endcase
      // Sticky flags: a new refusal wins over a clear
      nxt_st.err = (st_ff.err & ~err_clr) | err_set;
      // Front end follows the stored words one cycle later
      nxt_st.front = dec_front;
      nxt_st.bus = AQC_ST_IDLE;
      // Address phase
      if (take)
      begin
         nxt_st.waddr = haddr;
         if (hwrite)
         begin
            nxt_st.bus = AQC_ST_WDATA;
         end
         else if (rd_slot != AQC_SLOT_NONE)
         begin
            // Read sees a write finishing in this same cycle
            nxt_st.rdata = 32'(nxt_st.ctrl[rd_slot]);
         end
         else if (haddr == AQC_OFF_STAT)
         begin
            nxt_st.rdata = 32'(nxt_st.err);
         end
         else
         begin
            // Unmapped address reads zero
            nxt_st.rdata = '0;
         end
      end
   end

   // ==================================================================
   // State register
   // ==================================================================
   // Single flop bank for the whole state
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_ff.bus <= AQC_ST_IDLE;
         st_ff.waddr <= '0;
         st_ff.ctrl <= {AQC_NSLOT{aqc_chan_ctrl_t'(AQC_CTRL_RST)}};
         st_ff.front <= {AQC_NSLOT{aqc_front_t'(AQC_FRONT_RST)}};
         st_ff.err <= '0;
         st_ff.rdata <= '0;
         st_ff.ready <= 1'b1;
         st_ff.resp <= AQC_HRESP_OKAY;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // ==================================================================
   // Outputs
   // ==================================================================
   // All outputs straight from the state flops
   assign hrdata = st_ff.rdata;
   assign hreadyout = st_ff.ready;
   assign hresp = st_ff.resp;
   assign chan_front = st_ff.front;

   // ==================================================================
   // Assertions
   // ==================================================================
   default clocking aqc_cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   generate
      for (genvar g = 0; g < AQC_NSLOT; g++)
      begin : g_chk
         // Exactly one converter source reaches the converter
         src_onehot_a: assert property (
            $onehot({st_ff.front[g].sel_prescale, st_ff.front[g].sel_direct,
                     st_ff.front[g].sel_monitor}))
            else $error("source select not one-hot");

         // Stored source never holds the unused code
         src_valid_a: assert property (
            st_ff.ctrl[g].src != AQC_SRC_INVALID)
            else $error("invalid source stored");

         // Invalid source write keeps old source and raises its flag
         bad_src_keep_a: assert property (
            (st_ff.bus == AQC_ST_WDATA && wr_slot == 2'(g) &&
             wr_in.src == AQC_SRC_INVALID)
            |=> (st_ff.ctrl[g].src == $past(st_ff.ctrl[g].src)) &&
                st_ff.err.src_bad[g])
            else $error("invalid source not refused");

         // Switch output follows the stored bit two cycles after a write
         switch_follow_a: assert property (
            (st_ff.bus == AQC_ST_WDATA && wr_slot == 2'(g))
            |=> ##1 (st_ff.front[g].switch_on == $past(wr_in.sw_on, 2)))
            else $error("switch control does not follow write");

         // Polarity output mirrors the stored polarity bit
         pol_follow_a: assert property (
            st_ff.front[g].neg_pol == $past(st_ff.ctrl[g].neg_pol))
            else $error("polarity output wrong");

         // Source selects follow the stored source code one cycle later
         src_follow_a: assert property (
            {st_ff.front[g].sel_prescale, st_ff.front[g].sel_direct,
             st_ff.front[g].sel_monitor} ==
            {$past(st_ff.ctrl[g].src) == AQC_SRC_PRESCALE,
             $past(st_ff.ctrl[g].src) == AQC_SRC_DIRECT,
             $past(st_ff.ctrl[g].src) == AQC_SRC_MONITOR})
            else $error("source select does not follow stored code");

         // Range lines follow the stored range bits one cycle later
         rng_follow_a: assert property (
            st_ff.front[g].rng == $past(st_ff.ctrl[g].rng))
            else $error("range output wrong");
      end
   endgenerate

   // Temperature channel stays positive with an allowed range
   temp_limits_a: assert property (
      !st_ff.ctrl[AQC_SLOT_TEMP].neg_pol &&
      aqc_temp_rng_ok(st_ff.ctrl[AQC_SLOT_TEMP].rng) &&
      !st_ff.front[AQC_SLOT_TEMP].neg_pol)
      else $error("temperature channel setting out of limits");

   // Legal word at the temperature offset lands in the temperature slot
   temp_map_a: assert property (
      (st_ff.bus == AQC_ST_WDATA && st_ff.waddr == AQC_OFF_TEMP &&
       wr_in.src != AQC_SRC_INVALID && !wr_in.neg_pol && aqc_temp_rng_ok(wr_in.rng))
      |=> (st_ff.ctrl[AQC_SLOT_TEMP] == $past(wr_in)) &&
          $stable(st_ff.ctrl[AQC_SLOT_VOLT]) && $stable(st_ff.ctrl[AQC_SLOT_CURR]))
      else $error("temperature write misplaced");

   // Illegal temperature range write keeps the range and flags it
   temp_rng_keep_a: assert property (
      (st_ff.bus == AQC_ST_WDATA && wr_slot == AQC_SLOT_TEMP &&
       !aqc_temp_rng_ok(wr_in.rng))
      |=> $stable(st_ff.ctrl[AQC_SLOT_TEMP].rng) && st_ff.err.trng_bad)
      else $error("temperature range not refused");

   // Write one to clear empties every flag that was written as one
   stat_clear_a: assert property (
      (st_ff.bus == AQC_ST_WDATA && st_ff.waddr == AQC_OFF_STAT)
      |=> ((st_ff.err & $past(err_clr)) == '0))
      else $error("status flags not cleared");

   // Refused source code seen on any channel
   cover_src_bad_c: cover property (st_ff.err.src_bad != '0);

   // Monitor amplifier selected on the temperature channel
   cover_tmon_c: cover property (st_ff.front[AQC_SLOT_TEMP].sel_monitor);

   // Negative polarity write to temperature channel is refused
   cover_tpol_c: cover property (
      st_ff.bus == AQC_ST_WDATA && wr_slot == AQC_SLOT_TEMP && wr_in.neg_pol);

   // Monitor amplifier selected on the current channel
   cover_mon_c: cover property (st_ff.front[AQC_SLOT_CURR].sel_monitor);

   // Direct input closed on the voltage channel
   cover_direct_c: cover property (
      st_ff.front[AQC_SLOT_VOLT].sel_direct && st_ff.front[AQC_SLOT_VOLT].switch_on);

endmodule // aqc_quad_ctrl

/* File: core/aqc_pkg.sv */
/*
   Shared definitions for the analog quad input configuration block:
   register offsets, control word layout, source codes, reset values,
   bus constants and the state record of the top module.
   Assumes a single AHB-Lite master with 32-bit word transfers.
*/
// ====================================================================
// Package
// ====================================================================
package aqc_pkg;

   // Number of configured channels in one quad
   localparam int AQC_NSLOT = 3;

   // Channel index of each input inside the quad
   localparam logic [1:0] AQC_CHIDX_VOLT = 2'h0;
   localparam logic [1:0] AQC_CHIDX_CURR = 2'h1;
   localparam logic [1:0] AQC_CHIDX_TEMP = 2'h3;

   // Register byte offsets, one word per channel index
   localparam logic [31:0] AQC_OFF_VOLT = 32'h0000_0000;
   localparam logic [31:0] AQC_OFF_CURR = 32'h0000_0004;
   localparam logic [31:0] AQC_OFF_TEMP = 32'h0000_000c;
   localparam logic [31:0] AQC_OFF_STAT = 32'h0000_0010;

   // Internal slot numbers of the three channels
   localparam logic [1:0] AQC_SLOT_VOLT = 2'h0;
   localparam logic [1:0] AQC_SLOT_CURR = 2'h1;
   localparam logic [1:0] AQC_SLOT_TEMP = 2'h2;
   localparam logic [1:0] AQC_SLOT_NONE = 2'h3;

   // Converter source select codes
   typedef enum logic [1:0] {
      AQC_SRC_PRESCALE = 2'h0,
      AQC_SRC_DIRECT   = 2'h1,
      AQC_SRC_MONITOR  = 2'h2,
      AQC_SRC_INVALID  = 2'h3
   } aqc_src_t;

   // Prescaler ranges allowed on the temperature channel
   localparam logic [2:0] AQC_RNG_16V = 3'h0;
   localparam logic [2:0] AQC_RNG_4V = 3'h2;

   // Channel control lines: polarity, switch, source, range
   typedef struct packed {
      logic neg_pol;
      logic sw_on;
      aqc_src_t src;
      logic [2:0] rng;
   } aqc_chan_ctrl_t;

   localparam int AQC_CTRL_W = $bits(aqc_chan_ctrl_t);
   localparam logic [6:0] AQC_CTRL_RST = 7'h00;

   // Decoded controls toward the analog front end
   typedef struct packed {
      logic sel_prescale;
      logic sel_direct;
      logic sel_monitor;
      logic switch_on;
      logic neg_pol;
      logic [2:0] rng;
   } aqc_front_t;

   localparam logic [7:0] AQC_FRONT_RST = 8'h80;

   // Sticky status of refused settings
   typedef struct packed {
      logic trng_bad;
      logic tpol_bad;
      logic [2:0] src_bad;
   } aqc_err_t;

   localparam int AQC_ERR_W = $bits(aqc_err_t);

   // Bus phase tracking, one-hot
   typedef enum logic [1:0] {
      AQC_ST_IDLE  = 2'b01,
      AQC_ST_WDATA = 2'b10
   } aqc_bus_st_t;

   // AHB-Lite constants
   localparam int AQC_HTRANS_ACT = 1;
   localparam logic [2:0] AQC_HSIZE_WORD = 3'h2;
   localparam logic AQC_HRESP_OKAY = 1'h0;

   // Whole state of the top module
   typedef struct packed {
      aqc_bus_st_t bus;
      logic [31:0] waddr;
      aqc_chan_ctrl_t [AQC_NSLOT-1:0] ctrl;
      aqc_front_t [AQC_NSLOT-1:0] front;
      aqc_err_t err;
      logic [31:0] rdata;
      logic ready;
      logic resp;
   } aqc_state_t;

   // Slot addressed by a byte address, or none
   function automatic logic [1:0] aqc_slot_of(input logic [31:0] a);
      case (a)
         AQC_OFF_VOLT: aqc_slot_of = AQC_SLOT_VOLT;
         AQC_OFF_CURR: aqc_slot_of = AQC_SLOT_CURR;
         AQC_OFF_TEMP: aqc_slot_of = AQC_SLOT_TEMP;
         default: aqc_slot_of = AQC_SLOT_NONE;
      endcase
   endfunction

   // Range code usable by the temperature monitor
   function automatic logic aqc_temp_rng_ok(input logic [2:0] r);
      aqc_temp_rng_ok = (r == AQC_RNG_16V) || (r == AQC_RNG_4V);
   endfunction

endpackage

/* File: core/aqc_chan_decode.sv */
/*
   Decoder for one channel: turns the stored control lines into the
   source select, one-hot for the three legal codes, and the switch and polarity controls of the front end.
   Assumes the caller registers the result before it leaves the block.
*/
// ====================================================================
// Channel decoder
// ====================================================================
module aqc_chan_decode
   import aqc_pkg::*;
(
   // Stored control lines of the channel
   input wire aqc_chan_ctrl_t ctrl,
   // Decoded front end controls
   output aqc_front_t front
);

   // Source mux, switch and polarity decode
   always_comb
   begin
      front = aqc_front_t'(AQC_FRONT_RST);
      front.sel_prescale = 1'b0;
      // One select per legal source; the unused code selects nothing
      case (ctrl.src)
         AQC_SRC_PRESCALE: front.sel_prescale = 1'b1;
         AQC_SRC_DIRECT: front.sel_direct = 1'b1;
         AQC_SRC_MONITOR: front.sel_monitor = 1'b1;
         default: front.sel_prescale = 1'b0;
      endcase
      front.switch_on = ctrl.sw_on;
      front.neg_pol = ctrl.neg_pol;
      front.rng = ctrl.rng;
   end

endmodule // aqc_chan_decode

/* File: verif/aqc_front_model.sv */
/*
   Model of the analog front end and converter input mux of one quad.
   Assumes chan_front slot 0 voltage, 1 current, 2 temperature.
*/
// ====================================================================
// Front end model
// ====================================================================
module aqc_front_model
   import aqc_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Decoded controls
   input wire aqc_front_t [AQC_NSLOT-1:0] chan_front,
   // Direct switch closed and negative polarity per slot
   output logic [AQC_NSLOT-1:0] sw_closed,
   output logic [AQC_NSLOT-1:0] neg_in,
   // Sticky flag of an illegal setting seen
   output logic fault_ff
);
   timeunit 1ns;
   timeprecision 1ps;
   // Switch and polarity follow the lines directly
   always_comb
   begin
      for (int i = 0; i < AQC_NSLOT; i++)
      begin
         sw_closed[i] = chan_front[i].switch_on;
         neg_in[i] = chan_front[i].neg_pol;
      end
   end
   // Mux needs one source; temperature input is positive, ranges 000/010
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         fault_ff <= 1'b0;
      else
      begin
         for (int i = 0; i < AQC_NSLOT; i++)
            if ((chan_front[i].sel_prescale + chan_front[i].sel_direct
                 + chan_front[i].sel_monitor) != 2'h1)
               fault_ff <= 1'b1;
         if (chan_front[2].neg_pol !== 1'b0)
            fault_ff <= 1'b1;
         if (!(chan_front[2].rng inside {3'h0, 3'h2}))
            fault_ff <= 1'b1;
      end
   end
endmodule // aqc_front_model

/* File: verif/aqc_quad_ctrl_test.sv */
/*
   Self-checking bench for the quad configuration block.
   Assumes one AHB-Lite master, hready looped from hreadyout.
*/
// ====================================================================
// Testbench
// ====================================================================
module aqc_quad_ctrl_test
   import aqc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // Bus signals
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   wire logic hready;
   aqc_front_t [AQC_NSLOT-1:0] chan_front;
   logic [AQC_NSLOT-1:0] sw_closed;
   logic [AQC_NSLOT-1:0] neg_in;
   logic fault_ff;
   // Expected control words, status and counters
   logic [6:0] cw [3];
   logic [4:0] st;
   logic [31:0] rd;
   int miscompares = 0;
   int checks = 0;
   // Single slave owns the bus ready
   assign hready = hreadyout;
   always #5 hclk = ~hclk;
   aqc_quad_ctrl aqc_quad_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .chan_front(chan_front));
   aqc_front_model aqc_front_model_i (.hclk(hclk), .hresetn(hresetn),
      .chan_front(chan_front), .sw_closed(sw_closed), .neg_in(neg_in),
      .fault_ff(fault_ff));
   // Compare and count
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Verdict and end of run
   task print_verdict();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // One AHB-Lite single transfer; entered just after a rising edge
   task bus(input logic [31:0] a, input logic w, input logic [31:0] d,
            input logic [2:0] sz);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      hsize <= sz;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
      chk("hresp", {31'h0, hresp}, {31'h0, AQC_HRESP_OKAY});
   endtask
   // Byte address of a slot
   function automatic logic [31:0] adr(input int s);
      adr = (s == 2) ? AQC_OFF_TEMP : (s == 1) ? AQC_OFF_CURR : AQC_OFF_VOLT;
   endfunction
   // Front end lines expected for a stored word
   function automatic logic [31:0] fexp(input logic [6:0] w);
      fexp = {24'h0, w[4:3] == 2'h0, w[4:3] == 2'h1, w[4:3] == 2'h2, w[5], w[6], w[2:0]};
   endfunction
   // Write a control word, predict refusals, check lines and readback
   task wr_ctrl(input int s, input logic [6:0] w);
      logic [6:0] n;
      n = w;
      if (w[4:3] == 2'h3)
      begin
         n[4:3] = cw[s][4:3];
         st[s] = 1'b1;
      end
      if (s == 2 && w[6])
      begin
         n[6] = 1'b0;
         st[3] = 1'b1;
      end
      if (s == 2 && !(w[2:0] == 3'h0 || w[2:0] == 3'h2))
      begin
         n[2:0] = cw[s][2:0];
         st[4] = 1'b1;
      end
      cw[s] = n;
      bus(adr(s), 1'b1, {25'h1ffffff, w}, AQC_HSIZE_WORD);
      repeat (2) @(posedge hclk);
      #1;
      chk("front", {24'h0, chan_front[s]}, fexp(cw[s]));
      chk("switch", {31'h0, sw_closed[s]}, {31'h0, cw[s][5]});
      chk("polarity", {31'h0, neg_in[s]}, {31'h0, cw[s][6]});
      @(posedge hclk);
      bus(adr(s), 1'b0, 32'h0, AQC_HSIZE_WORD);
      chk("ctrl", rd, {25'h0, cw[s]});
      bus(AQC_OFF_STAT, 1'b0, 32'h0, AQC_HSIZE_WORD);
      chk("status", rd, {27'h0, st});
   endtask
   // Reset values of the front end lines, hreadyout and hrdata
   task chk_reset();
      for (int s = 0; s < 3; s++)
         chk("front rst", {24'h0, chan_front[s]}, {24'h0, AQC_FRONT_RST});
      chk("ready rst", {31'h0, hreadyout}, 32'h1);
      chk("rdata rst", hrdata, 32'h0);
   endtask
   // Watchdog
   initial
   begin
      #200000;
      miscompares++;
      print_verdict();
   end
   // Main sequence
   initial
   begin
      logic [6:0] codes [8];
      codes = '{7'h00, 7'h08, 7'h10, 7'h18, 7'h7f, 7'h22, 7'h47, 7'h6a};
      for (int s = 0; s < 3; s++)
         cw[s] = AQC_CTRL_RST;
      st = 5'h0;
      repeat (5) @(posedge hclk);
      #1;
      chk_reset();
      @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // Each of the eight listed codes on every channel
      for (int s = 0; s < 3; s++)
         for (int c = 0; c < 8; c++)
            wr_ctrl(s, codes[c]);
      // Index 2 is no channel; write ignored, reads zero
      bus(32'h8, 1'b1, 32'h7f, AQC_HSIZE_WORD);
      bus(32'h8, 1'b0, 32'h0, AQC_HSIZE_WORD);
      chk("unmapped", rd, 32'h0);
      // Byte-size write must leave the word alone
      bus(AQC_OFF_VOLT, 1'b1, 32'h55, 3'h0);
      bus(AQC_OFF_VOLT, 1'b0, 32'h0, AQC_HSIZE_WORD);
      chk("sized", rd, {25'h0, cw[0]});
      // Clear status, then refuse a temperature setting again
      bus(AQC_OFF_STAT, 1'b1, 32'h1f, AQC_HSIZE_WORD);
      st = 5'h0;
      wr_ctrl(2, 7'h5b);
      chk("model", {31'h0, fault_ff}, 32'h0);
      // Second reset in mid-run
      hresetn <= 1'b0;
      @(posedge hclk);
      #1;
      chk_reset();
      @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // Block works again after the second release, status starts clear
      for (int s = 0; s < 3; s++)
         cw[s] = AQC_CTRL_RST;
      st = 5'h0;
      wr_ctrl(1, 7'h10);
      print_verdict();
   end
endmodule // aqc_quad_ctrl_test
